//--- hdl/sqcl_regs.svh
`ifndef SQCL_REGS_SVH
`define SQCL_REGS_SVH
// number of rails one device controls
`define SQCL_RAILS 4
// pin input synchroniser depth
`define SQCL_SYNC_STAGES 3
// one less than the cycles between switching successive rails off (and on)
`define SQCL_STEP_CYCLES 8'h04
`define SQCL_STEP_RESET 8'h00
`endif

//--- hdl/sqcl_pkg.sv
package sqcl_pkg;
	typedef enum logic [2:0] {
		SQCL_OFF = 3'b000,
		SQCL_WAIT_UP = 3'b001,
		SQCL_RAMP_ON = 3'b010,
		SQCL_ON = 3'b011,
		SQCL_WAIT_DN = 3'b100,
		SQCL_RAMP_OFF = 3'b101
	} sqcl_state_t;
	// reaction of this device to a low shared fault line
	typedef enum logic [1:0] {
		SQCL_RESP_IGNORE = 2'b00,
		SQCL_RESP_SHUTDOWN = 2'b01,
		SQCL_RESP_LATCH = 2'b10
	} sqcl_resp_t;
endpackage

//--- hdl/sqcl_pin_sync.sv
`timescale 1ns/100ps
`include "sqcl_regs.svh"
module sqcl_pin_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// raw pin and filtered level
	input wire logic pinRaw,
	output logic pinLevel
);
	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_q;
	logic level_d;

	always_comb begin
		stage_d = {stage_q[1:0], pinRaw};
		level_d = level_q;
		if (stage_q[2] == stage_q[1]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage_q <= 3'h0;
			level_q <= 1'b0;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

	assign pinLevel = level_q;
endmodule

//--- hdl/sqcl_cascade_link.sv
// Functional notes
// - railsAllOff is high only in the cycle after every rail of this device was below its off threshold.
// - the downstream all-off input, once enabled as off dependency, holds rails on until high.
// - on power request withdrawal the last device in the chain switches off first.
// - the master starts its own off ramp only after all slave rails report off.
// - the fault pin is two-way so several devices may share one pulled-up bus.
// - with no local fault the fault pin is left as an input and its level is watched.
// - a local rail fault drives the fault pin low.
// - a low fault bus triggers the configured response on every device except the one driving it.
// - when the local fault clears the pin is released back to input.
// - rails only power on after the upstream device reports its rails in regulation.
// - with fault handling enabled, deassertion of the general input counts as a fault.
`timescale 1ns/100ps
`include "sqcl_regs.svh"
module sqcl_cascade_link
	import sqcl_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// host and configuration
	input wire logic powerRequest,
	input wire logic upstreamDepEn,
	input wire logic downstreamDepEn,
	input wire logic generalFaultEn,
	input wire sqcl_pkg::sqcl_resp_t faultResponse,
	input wire logic faultClear,
	// rail monitors
	input wire logic [`SQCL_RAILS-1:0] railAboveGood,
	input wire logic [`SQCL_RAILS-1:0] railBelowOff,
	input wire logic [`SQCL_RAILS-1:0] railFault,
	output logic [`SQCL_RAILS-1:0] railEnable,
	// cascade pins
	input wire logic upstreamGoodPin,
	input wire logic downstreamOffPin,
	input wire logic generalInputPin,
	output logic railsInRegulation,
	output logic railsAllOff,
	// shared fault bus
	input wire logic faultBusIn,
	output logic faultBusOut,
	output logic faultBusOe,
	output logic faultReacting
);
	import sqcl_pkg::*;

	logic upGood;
	logic downOff;
	logic genIn;
	logic busLevel;
	sqcl_state_t state_q;
	sqcl_state_t state_d;
	logic [7:0] step_q;
	logic [7:0] step_d;
	logic [`SQCL_RAILS-1:0] en_q;
	logic [`SQCL_RAILS-1:0] en_d;
	logic good_q;
	logic good_d;
	logic off_q;
	logic off_d;
	logic oe_q;
	logic oe_d;
	logic latch_q;
	logic latch_d;
	logic react_q;
	logic react_d;
	logic localFault;
	logic busFault;
	logic shutNow;
	logic upOk;
	logic downOk;
	logic [4:0] oeHist_q;
	logic [4:0] oeHist_d;

	genvar gi;
	// per-pin three-stage synchronisers
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			logic rawPin;
			logic syncOut;
			// idle-high pins enter inverted so the reset state reads idle
			assign rawPin = (gi == 0) ? upstreamGoodPin :
				(gi == 1) ? downstreamOffPin :
				(gi == 2) ? !generalInputPin : !faultBusIn;
			sqcl_pin_sync u_sync (
				.sys_clk(sys_clk),
				.srst(srst),
				.pinRaw(rawPin),
				.pinLevel(syncOut)
			);
		end
	endgenerate
	assign upGood = g_sync[0].syncOut;
	assign downOff = g_sync[1].syncOut;
	assign genIn = !g_sync[2].syncOut;
	assign busLevel = !g_sync[3].syncOut;

	assign localFault = (|railFault) || (generalFaultEn && !genIn);
	// own drive, and its echo still in the synchroniser, is not a foreign fault
	assign busFault = !busLevel && !oe_q && !(|oeHist_q);
	assign shutNow = latch_q || (busFault && faultResponse != SQCL_RESP_IGNORE) || localFault;
	assign upOk = !upstreamDepEn || upGood;
	assign downOk = !downstreamDepEn || downOff;

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		en_d = en_q;
		if (step_q != `SQCL_STEP_RESET) begin
			step_d = step_q - 8'h01;
		end
		if (shutNow) begin
			en_d = '0;
			state_d = SQCL_OFF;
			step_d = `SQCL_STEP_RESET;
		end else begin
			case (state_q)
				SQCL_OFF: begin
					if (powerRequest) begin
						state_d = SQCL_WAIT_UP;
					end
				end
				SQCL_WAIT_UP: begin
					if (!powerRequest) begin
						state_d = SQCL_OFF;
					end else if (upOk) begin
						state_d = SQCL_RAMP_ON;
					end
				end
				SQCL_RAMP_ON: begin
					if (!powerRequest) begin
						state_d = SQCL_WAIT_DN;
					end else if (&en_q) begin
						state_d = SQCL_ON;
					end else if (step_q == `SQCL_STEP_RESET && upOk) begin
						en_d = {en_q[`SQCL_RAILS-2:0], 1'b1};
						step_d = `SQCL_STEP_CYCLES;
					end
				end
				SQCL_ON: begin
					if (!powerRequest) begin
						state_d = SQCL_WAIT_DN;
					end
				end
				SQCL_WAIT_DN: begin
					// hold rails until downstream reports all off
					if (powerRequest) begin
						state_d = SQCL_RAMP_ON;
					end else if (downOk) begin
						state_d = SQCL_RAMP_OFF;
						step_d = `SQCL_STEP_RESET;
					end
				end
				SQCL_RAMP_OFF: begin
					if (en_q == '0) begin
						state_d = SQCL_OFF;
					end else if (step_q == `SQCL_STEP_RESET) begin
						// last rail on is first off
						en_d = {1'b0, en_q[`SQCL_RAILS-1:1]};
						step_d = `SQCL_STEP_CYCLES;
					end
				end
				default: begin
					state_d = SQCL_OFF;
					en_d = '0;
				end
			endcase
		end
	end

	always_comb begin
		good_d = (&railAboveGood) && (&en_q);
		off_d = &railBelowOff;
		oe_d = localFault;
		oeHist_d = {oeHist_q[3:0], oe_q};
		latch_d = latch_q;
		if (busFault && faultResponse == SQCL_RESP_LATCH) begin
			latch_d = 1'b1;
		end else if (faultClear) begin
			latch_d = 1'b0;
		end
		react_d = busFault && faultResponse != SQCL_RESP_IGNORE;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= SQCL_OFF;
			step_q <= `SQCL_STEP_RESET;
			en_q <= '0;
			good_q <= 1'b0;
			off_q <= 1'b0;
			oe_q <= 1'b0;
			oeHist_q <= 5'h00;
			latch_q <= 1'b0;
			react_q <= 1'b0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			en_q <= en_d;
			good_q <= good_d;
			off_q <= off_d;
			oe_q <= oe_d;
			oeHist_q <= oeHist_d;
			latch_q <= latch_d;
			react_q <= react_d;
		end
	end

	assign railEnable = en_q;
	assign railsInRegulation = good_q;
	assign railsAllOff = off_q;
	assign faultBusOut = 1'b0;
	assign faultBusOe = oe_q;
	assign faultReacting = react_q;

	property p_alloff;
		@(posedge sys_clk) disable iff (srst) railsAllOff |-> $past(&railBelowOff);
	endproperty
	a_alloff: assert property (p_alloff) else $error("all-off without rails off");

	property p_downdep;
		@(posedge sys_clk) disable iff (srst)
			(state_q == SQCL_WAIT_DN && !downOk && !shutNow && !powerRequest) |=> en_q == $past(en_q);
	endproperty
	a_downdep: assert property (p_downdep) else $error("rails dropped before downstream off");

	property p_offorder;
		@(posedge sys_clk) disable iff (srst)
			(state_q == SQCL_RAMP_OFF && $past(state_q) != SQCL_RAMP_OFF) |-> $past(downOk);
	endproperty
	a_offorder: assert property (p_offorder) else $error("off ramp without downstream off");

	property p_master;
		@(posedge sys_clk) disable iff (srst)
			(en_q < $past(en_q) && !$past(shutNow)) |-> $past(downOk);
	endproperty
	a_master: assert property (p_master) else $error("master ramped down early");

	property p_never_high;
		@(posedge sys_clk) disable iff (srst) faultBusOe |-> !faultBusOut;
	endproperty
	a_never_high: assert property (p_never_high) else $error("fault bus driven high");

	property p_release;
		@(posedge sys_clk) disable iff (srst) !$past(localFault) |-> !faultBusOe;
	endproperty
	a_release: assert property (p_release) else $error("fault pin not released");

	property p_drive;
		@(posedge sys_clk) disable iff (srst) (|railFault) |=> faultBusOe;
	endproperty
	a_drive: assert property (p_drive) else $error("fault pin not driven");

	property p_react;
		@(posedge sys_clk) disable iff (srst)
			(busFault && faultResponse != SQCL_RESP_IGNORE) |=> railEnable == '0;
	endproperty
	a_react: assert property (p_react) else $error("no response to fault bus");

	property p_gen;
		@(posedge sys_clk) disable iff (srst) (generalFaultEn && !genIn) |=> railEnable == '0;
	endproperty
	a_gen: assert property (p_gen) else $error("general input fault ignored");

	property p_up;
		@(posedge sys_clk) disable iff (srst) $rose(en_q[0]) |-> $past(upOk);
	endproperty
	a_up: assert property (p_up) else $error("power on without upstream good");

	c_on: cover property (@(posedge sys_clk) state_q == SQCL_ON);
	c_off: cover property (@(posedge sys_clk) state_q == SQCL_RAMP_OFF ##[1:40] state_q == SQCL_OFF);
	c_fault: cover property (@(posedge sys_clk) faultBusOe);
	c_react: cover property (@(posedge sys_clk) faultReacting);
endmodule

//--- verif/sqcl_peer_model.sv
`timescale 1ns/100ps
`include "sqcl_regs.svh"
module sqcl_peer_model (
	// clock
	input wire logic sys_clk,
	// local rails
	input wire logic [`SQCL_RAILS-1:0] railEnable,
	output logic [`SQCL_RAILS-1:0] railAboveGood,
	output logic [`SQCL_RAILS-1:0] railBelowOff,
	// downstream peer
	input wire logic peerOn,
	output logic peerAllOff,
	// fault bus
	input wire logic dutOe,
	input wire logic peerPull,
	output logic busLevel
);
	logic [`SQCL_RAILS-1:0] railLevel = '0;
	logic [3:0] peerRails = 4'h0;
	always @(posedge sys_clk) begin
		railLevel <= railEnable;
		peerRails <= peerOn ? {peerRails[2:0], 1'b1} : {1'b0, peerRails[3:1]};
	end
	assign railAboveGood = railLevel;
	assign railBelowOff = ~railLevel;
	// peer rails drop one by one before all-off shows
	assign peerAllOff = peerRails == 4'h0;
	// pull-up bus, open-drain drivers only
	assign busLevel = ~(dutOe | peerPull);
endmodule

//--- verif/test_sqcl_cascade_link.sv
`timescale 1ns/100ps
module test_sqcl_cascade_link;
	import sqcl_pkg::*;
	logic sys_clk = 0, srst = 1, powerRequest = 0, upDep = 1, dnDep = 1, genEn = 0;
	logic upGood = 0, genPin = 1, peerOn = 0, peerPull = 0, faultClear = 0;
	sqcl_resp_t faultResponse = SQCL_RESP_IGNORE;
	logic [3:0] railFault = 4'h0, railEnable, aboveGood, belowOff;
	logic inReg, allOff, peerAllOff, busLevel, busOut, busOe, reacting;
	int failures = 0, num_checks = 0, cycles = 0;
	always #2.5 sys_clk = ~sys_clk;
	sqcl_cascade_link i_sqcl_cascade_link (.sys_clk(sys_clk), .srst(srst),
		.powerRequest(powerRequest), .upstreamDepEn(upDep), .downstreamDepEn(dnDep),
		.generalFaultEn(genEn), .faultResponse(faultResponse), .faultClear(faultClear),
		.railAboveGood(aboveGood), .railBelowOff(belowOff), .railFault(railFault),
		.railEnable(railEnable), .upstreamGoodPin(upGood), .downstreamOffPin(peerAllOff),
		.generalInputPin(genPin), .railsInRegulation(inReg), .railsAllOff(allOff),
		.faultBusIn(busLevel), .faultBusOut(busOut), .faultBusOe(busOe),
		.faultReacting(reacting));
	sqcl_peer_model i_sqcl_peer_model (.sys_clk(sys_clk), .railEnable(railEnable),
		.railAboveGood(aboveGood), .railBelowOff(belowOff), .peerOn(peerOn),
		.peerAllOff(peerAllOff), .dutOe(busOe), .peerPull(peerPull), .busLevel(busLevel));
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic waitFor(input logic [3:0] e);
		int n;
		n = 0;
		while (railEnable !== e && n < 100) begin
			cyc(1);
			n++;
		end
		chk("railEnable", e, railEnable);
	endtask
	task automatic t_reset;
		cyc(4);
		srst = 0;
		chk("railEnable", 4'h0, railEnable);
		chk("busOe", 4'h0, {3'h0, busOe});
		cyc(3);
		chk("allOff", 4'h1, {3'h0, allOff});
		$display("test reset done");
	endtask
	task automatic t_power;
		powerRequest = 1;
		peerOn = 1;
		cyc(30);
		chk("railEnable", 4'h0, railEnable);
		upGood = 1;
		waitFor(4'hf);
		cyc(2);
		chk("inReg", 4'h1, {3'h0, inReg});
		chk("allOff", 4'h0, {3'h0, allOff});
		powerRequest = 0;
		cyc(30);
		chk("railEnable", 4'hf, railEnable);
		peerOn = 0;
		waitFor(4'h7);
		waitFor(4'h0);
		cyc(3);
		chk("allOff", 4'h1, {3'h0, allOff});
		$display("test power done");
	endtask
	task automatic t_fault;
		powerRequest = 1;
		peerOn = 1;
		waitFor(4'hf);
		railFault = 4'h2;
		cyc(1);
		chk("busOe", 4'h1, {3'h0, busOe});
		chk("railEnable", 4'h0, railEnable);
		chk("busLevel", 4'h0, {3'h0, busLevel});
		chk("busOut", 4'h0, {3'h0, busOut});
		railFault = 4'h0;
		cyc(1);
		chk("busOe", 4'h0, {3'h0, busOe});
		powerRequest = 0;
		$display("test fault done");
	endtask
	task automatic t_bus;
		peerPull = 1;
		cyc(8);
		chk("reacting", 4'h0, {3'h0, reacting});
		faultResponse = SQCL_RESP_SHUTDOWN;
		cyc(2);
		chk("reacting", 4'h1, {3'h0, reacting});
		chk("busOe", 4'h0, {3'h0, busOe});
		peerPull = 0;
		cyc(8);
		chk("reacting", 4'h0, {3'h0, reacting});
		genEn = 1;
		genPin = 0;
		cyc(8);
		chk("busOe", 4'h1, {3'h0, busOe});
		genPin = 1;
		cyc(8);
		chk("busOe", 4'h0, {3'h0, busOe});
		$display("test bus done");
	endtask
	task automatic t_latch;
		faultResponse = SQCL_RESP_LATCH;
		powerRequest = 1;
		waitFor(4'hf);
		peerPull = 1;
		cyc(8);
		chk("railEnable", 4'h0, railEnable);
		chk("reacting", 4'h1, {3'h0, reacting});
		peerPull = 0;
		cyc(20);
		chk("railEnable", 4'h0, railEnable);
		faultClear = 1;
		cyc(1);
		faultClear = 0;
		waitFor(4'hf);
		upDep = 0;
		dnDep = 0;
		upGood = 0;
		powerRequest = 0;
		waitFor(4'h0);
		powerRequest = 1;
		waitFor(4'hf);
		$display("test latch done");
	endtask
	task automatic conclude;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		cyc(0);
		t_reset();
		t_power();
		t_fault();
		t_bus();
		t_latch();
		conclude();
	end
endmodule
